/* pkg/lfag_cfg.svh */
`ifndef LFAG_CFG_SVH
`define LFAG_CFG_SVH

// fuse byte defaults, 0 = programmed
`define LFAG_EXT_DEFAULT  8'h0F
`define LFAG_HIGH_DEFAULT 8'h99
`define LFAG_LOW_DEFAULT  8'h62
`define LFAG_LOCK_DEFAULT 8'hFF
// extended byte: only brown-out level bits exist
`define LFAG_EXT_USED_MASK 8'h07

// lock byte field positions
`define LFAG_LOCK_MEM_A    0
`define LFAG_LOCK_MEM_B    1
`define LFAG_LOCK_APP_LO   2
`define LFAG_LOCK_APP_HI   3
`define LFAG_LOCK_BOOT_LO  4
`define LFAG_LOCK_BOOT_HI  5

// high byte field positions
`define LFAG_HI_OCD        7
`define LFAG_HI_JTAG       6
`define LFAG_HI_SERIAL_DL  5
`define LFAG_HI_WDT_ON     4
`define LFAG_HI_EE_SAVE    3
`define LFAG_HI_BOOT_SZ_LSB 1
`define LFAG_HI_BOOT_RST   0

// low byte field positions
`define LFAG_LO_DIV8       7
`define LFAG_LO_CLOCK_OUTPUT_ENABLE      6
`define LFAG_LO_SUT_LSB    4
`define LFAG_LO_CKSEL_LSB  0

// signature space addresses
`define LFAG_SIG_ADDR0 2'h0
`define LFAG_SIG_ADDR1 2'h1
`define LFAG_SIG_ADDR2 2'h2

`endif

/* pkg/lfag_pkg.sv */
`default_nettype none
package lfag_pkg;

  typedef enum logic [1:0] {
    LFAG_SEL_LOW,
    LFAG_SEL_HIGH,
    LFAG_SEL_EXT,
    LFAG_SEL_LOCK
  } lfag_sel_e;

  typedef enum logic [1:0] {
    LFAG_MODE_NORMAL,
    LFAG_MODE_PROG
  } lfag_mode_e;

  // one cpu-side access request
  typedef struct packed {
    logic valid;
    logic is_store;
    logic from_boot;
    logic to_boot;
  } lfag_req_s;

  // decoded, applied configuration
  typedef struct packed {
    logic       onchip_debug_enable;
    logic       boundary_scan_enable;
    logic       serial_download_enable;
    logic       watchdog_always_on;
    logic       erase_preserve_eeprom;
    logic [1:0] boot_size;
    logic       boot_reset_vector_sel;
    logic       clock_div_eight;
    logic       clock_output_enable;
    logic [1:0] startup_time;
    logic [3:0] clock_source;
    logic [2:0] brownout_level;
  } lfag_cfg_s;

  typedef struct packed {
    lfag_mode_e mode;
    logic       pwr_seen;
    logic [7:0] ext_nv;
    logic [7:0] high_nv;
    logic [7:0] low_nv;
    logic [7:0] lock_nv;
    logic [7:0] ext_lat;
    logic [7:0] high_lat;
    logic [7:0] low_lat;
    logic       prog_s1;
    logic       prog_s2;
    logic       allow;
    logic       deny;
    logic       irq_mask;
    logic       refused;
    logic       done;
    logic [7:0] rdata;
    logic       rvalid;
    logic       ee_keep;
    lfag_cfg_s  cfg;
  } lfag_state_s;

endpackage : lfag_pkg
`default_nettype wire

/* rtl/lfag_guard.sv */
// Behaviour
// - app lock 11: stores and table reads of application unrestricted
// - app lock 10: stores to application blocked, table reads allowed
// - app lock 00: block stores, block boot-code table reads of application
// - app lock 01: block boot-code table reads of application, allow stores
// - app lock 0x, vectors in boot: mask interrupts in application code
// - boot lock 11: stores and table reads of boot unrestricted
// - boot lock 10: stores to boot blocked, table reads allowed
// - boot lock 00: block stores, block app-code table reads of boot
// - boot lock 01: block app-code table reads of boot, allow stores
// - boot lock 0x, vectors in application: mask interrupts in boot code
// - configuration bits read 0 when programmed, 1 when not
// - extended byte: bits 2:0 brown-out level, 7:3 read 0, default 0x0F
// - high byte layout per field order, default 0x99
// - low byte layout per field order, default 0x62
// - serial programming cannot read or alter serial-download enable bit
// - chip erase leaves configuration bytes unchanged
// - first memory lock bit programmed: configuration writes refused
// - fuses captured at programming entry, changes apply after exit
// - erase-preserve acts at once; keeps eeprom through chip erase
// - normal mode: fuses captured at power-up and applied
// - three signature bytes at 0x000..0x002, readable even when locked
// - lock bits return to 1 only by chip erase
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "lfag_cfg.svh"

module lfag_guard #(
  parameter logic [7:0] SIG_BYTE0 = 8'hA5, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h5A, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h3C  // arbitrary identity value
) (
  // clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               srst_in,
  // cpu access check
  input  wire lfag_pkg::lfag_req_s req_in,
  input  wire logic               vectors_in_boot_in,
  input  wire logic               exec_in_boot_in,
  output logic                    access_allow_out,
  output logic                    access_deny_out,
  output logic                    irq_mask_out,
  // programmer, asynchronous mode pin
  input  wire logic               prog_mode_in,
  input  wire logic               prog_serial_in,
  input  wire logic               prog_wr_in,
  input  wire logic               prog_rd_in,
  input  wire logic               prog_erase_in,
  input  wire logic               prog_sig_in,
  input  wire logic [1:0]         prog_sel_in,
  input  wire logic [7:0]         prog_wdata_in,
  output logic [7:0]              prog_rdata_out,
  output logic                    prog_rvalid_out,
  output logic                    prog_refused_out,
  output logic                    prog_done_out,
  // applied configuration
  output lfag_pkg::lfag_cfg_s     cfg_out,
  output logic                    eeprom_keep_out
);

  ////////////////////////////////////////////////////////////////////////
  function automatic lfag_pkg::lfag_cfg_s decode_cfg(
    input logic [7:0] e, input logic [7:0] h, input logic [7:0] l);
    lfag_pkg::lfag_cfg_s c;
    c.onchip_debug_enable    = h[`LFAG_HI_OCD];
    c.boundary_scan_enable   = h[`LFAG_HI_JTAG];
    c.serial_download_enable = h[`LFAG_HI_SERIAL_DL];
    c.watchdog_always_on     = h[`LFAG_HI_WDT_ON];
    c.erase_preserve_eeprom  = h[`LFAG_HI_EE_SAVE];
    c.boot_size              = h[`LFAG_HI_BOOT_SZ_LSB +: 2];
    c.boot_reset_vector_sel  = h[`LFAG_HI_BOOT_RST];
    c.clock_div_eight        = l[`LFAG_LO_DIV8];
    c.clock_output_enable    = l[`LFAG_LO_CLOCK_OUTPUT_ENABLE];
    c.startup_time           = l[`LFAG_LO_SUT_LSB +: 2];
    c.clock_source           = l[`LFAG_LO_CKSEL_LSB +: 4];
    c.brownout_level         = e[2:0];
    return c;
  endfunction : decode_cfg

  // one lock pair; own = executing code lives in the guarded section
  function automatic logic pair_ok(input logic hi, input logic lo,
                                   input logic is_store, input logic own);
    logic ok;
    ok = 1'b1;
    if (is_store) begin
      ok = lo;
    end else if (!hi && !own) begin
      ok = 1'b0;
    end
    return ok;
  endfunction : pair_ok

  ////////////////////////////////////////////////////////////////////////
  lfag_pkg::lfag_state_s s_q;
  lfag_pkg::lfag_state_s s_d;
  logic                  app_hi;
  logic                  app_lo;
  logic                  boot_hi;
  logic                  boot_lo;
  logic                  locked;
  logic                  in_prog;
  logic [7:0]            wmask;

  assign app_hi  = s_q.lock_nv[`LFAG_LOCK_APP_HI];
  assign app_lo  = s_q.lock_nv[`LFAG_LOCK_APP_LO];
  assign boot_hi = s_q.lock_nv[`LFAG_LOCK_BOOT_HI];
  assign boot_lo = s_q.lock_nv[`LFAG_LOCK_BOOT_LO];
  assign locked  = !s_q.lock_nv[`LFAG_LOCK_MEM_A];
  assign in_prog = (s_q.mode == lfag_pkg::LFAG_MODE_PROG);

  always_comb begin
    s_d         = s_q;
    s_d.refused = 1'b0;
    s_d.done    = 1'b0;
    s_d.rvalid  = 1'b0;
    wmask       = 8'hFF;
    // mode pin is asynchronous to the core clock
    s_d.prog_s1 = prog_mode_in;
    s_d.prog_s2 = s_q.prog_s1;

    // access check, decoded in the cycle of the request
    s_d.allow = 1'b0;
    s_d.deny  = 1'b0;
    if (req_in.valid) begin
      if (req_in.to_boot) begin
        s_d.allow = pair_ok(boot_hi, boot_lo, req_in.is_store,
                            req_in.from_boot);
      end else begin
        s_d.allow = pair_ok(app_hi, app_lo, req_in.is_store,
                            !req_in.from_boot);
      end
      s_d.deny = !s_d.allow;
    end
    s_d.irq_mask = (vectors_in_boot_in && !exec_in_boot_in && !app_hi)
                || (!vectors_in_boot_in && exec_in_boot_in && !boot_hi);

    // programming entry and exit
    case (s_q.mode)
      lfag_pkg::LFAG_MODE_NORMAL: begin
        if (s_q.prog_s2) begin
          s_d.mode     = lfag_pkg::LFAG_MODE_PROG;
          s_d.ext_lat  = s_q.ext_nv;
          s_d.high_lat = s_q.high_nv;
          s_d.low_lat  = s_q.low_nv;
        end
      end
      lfag_pkg::LFAG_MODE_PROG: begin
        if (!s_q.prog_s2) begin
          s_d.mode     = lfag_pkg::LFAG_MODE_NORMAL;
          s_d.ext_lat  = s_q.ext_nv;
          s_d.high_lat = s_q.high_nv;
          s_d.low_lat  = s_q.low_nv;
        end
      end
      default: s_d.mode = lfag_pkg::LFAG_MODE_NORMAL;
    endcase

    // first clock after reset is the power-up capture
    if (!s_q.pwr_seen) begin
      s_d.pwr_seen = 1'b1;
      s_d.ext_lat  = s_q.ext_nv;
      s_d.high_lat = s_q.high_nv;
      s_d.low_lat  = s_q.low_nv;
    end

    // programmer commands, honoured only inside a session
    if (in_prog && prog_erase_in) begin
      // fuse bytes untouched: only locks return to unprogrammed
      s_d.lock_nv = `LFAG_LOCK_DEFAULT;
      s_d.done    = 1'b1;
    end else if (in_prog && prog_wr_in) begin
      if (prog_sel_in == lfag_pkg::LFAG_SEL_LOCK) begin
        // writes only program bits; a 0 never returns to 1
        s_d.lock_nv = s_q.lock_nv & prog_wdata_in;
        s_d.done    = 1'b1;
      end else if (locked) begin
        s_d.refused = 1'b1;
      end else begin
        if (prog_serial_in) begin
          wmask[`LFAG_HI_SERIAL_DL] = 1'b0;
        end
        case (prog_sel_in)
          lfag_pkg::LFAG_SEL_LOW:  s_d.low_nv = prog_wdata_in;
          lfag_pkg::LFAG_SEL_HIGH: s_d.high_nv = (prog_wdata_in & wmask)
                                               | (s_q.high_nv & ~wmask);
          lfag_pkg::LFAG_SEL_EXT:
            s_d.ext_nv = prog_wdata_in & `LFAG_EXT_USED_MASK;
          default: s_d.low_nv = s_q.low_nv;
        endcase
        s_d.done = 1'b1;
      end
    end else if (in_prog && prog_rd_in) begin
      s_d.rvalid = 1'b1;
      if (prog_sig_in) begin
        // signature space ignores the lock state
        case (prog_sel_in)
          `LFAG_SIG_ADDR0: s_d.rdata = SIG_BYTE0;
          `LFAG_SIG_ADDR1: s_d.rdata = SIG_BYTE1;
          `LFAG_SIG_ADDR2: s_d.rdata = SIG_BYTE2;
          default:         s_d.rdata = 8'hFF;
        endcase
      end else begin
        // stored bits, 0 = programmed; extended bits 7:3 read 0, serial read of high shows download bit as 1
        case (prog_sel_in)
          lfag_pkg::LFAG_SEL_LOW:  s_d.rdata = s_q.low_nv;
          lfag_pkg::LFAG_SEL_HIGH: begin
            s_d.rdata = s_q.high_nv;
            if (prog_serial_in) begin
              s_d.rdata[`LFAG_HI_SERIAL_DL] = 1'b1;
            end
          end
          lfag_pkg::LFAG_SEL_EXT:  s_d.rdata = s_q.ext_nv & `LFAG_EXT_USED_MASK;
          default:                 s_d.rdata = s_q.lock_nv;
        endcase
      end
    end

    s_d.cfg = decode_cfg(s_q.ext_lat, s_q.high_lat, s_q.low_lat);
    // erase-preserve follows the stored bit, not the latch
    s_d.ee_keep = !s_q.high_nv[`LFAG_HI_EE_SAVE];
  end

  ////////////////////////////////////////////////////////////////////////
  // reset stands for power-on: cells come up at the default bytes, no image is kept
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s_q.mode     <= lfag_pkg::LFAG_MODE_NORMAL;
      s_q.pwr_seen <= 1'b0;
      s_q.ext_lat  <= `LFAG_EXT_DEFAULT;
      s_q.high_lat <= `LFAG_HIGH_DEFAULT;
      s_q.low_lat  <= `LFAG_LOW_DEFAULT;
      s_q.prog_s1  <= 1'b0;
      s_q.prog_s2  <= 1'b0;
      s_q.allow    <= 1'b0;
      s_q.deny     <= 1'b0;
      s_q.irq_mask <= 1'b0;
      s_q.refused  <= 1'b0;
      s_q.done     <= 1'b0;
      s_q.rdata    <= 8'h00;
      s_q.rvalid   <= 1'b0;
      s_q.ee_keep  <= 1'b0;
      s_q.cfg      <= '0;
      s_q.ext_nv   <= `LFAG_EXT_DEFAULT;
      s_q.high_nv  <= `LFAG_HIGH_DEFAULT;
      s_q.low_nv   <= `LFAG_LOW_DEFAULT;
      s_q.lock_nv  <= `LFAG_LOCK_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign access_allow_out = s_q.allow;
  assign access_deny_out  = s_q.deny;
  assign irq_mask_out     = s_q.irq_mask;
  assign prog_rdata_out   = s_q.rdata;
  assign prog_rvalid_out  = s_q.rvalid;
  assign prog_refused_out = s_q.refused;
  assign prog_done_out    = s_q.done;
  assign cfg_out          = s_q.cfg;
  assign eeprom_keep_out  = s_q.ee_keep;

  ////////////////////////////////////////////////////////////////////////
  default clocking chk_cb @(posedge core_clk_in);
  endclocking
  default disable iff (srst_in);

  a_app_store_lock: assert property (
    req_in.valid && req_in.is_store && !req_in.to_boot && !app_lo
    |=> access_deny_out)
    else $error("store to locked application allowed");
  a_app_store_open: assert property (
    req_in.valid && req_in.is_store && !req_in.to_boot && app_lo
    |=> access_allow_out)
    else $error("application store wrongly denied");
  a_app_read_open: assert property (
    req_in.valid && !req_in.is_store && !req_in.to_boot && app_hi
    |=> access_allow_out)
    else $error("application table read denied");
  a_app_cross_read: assert property (
    req_in.valid && !req_in.is_store && !req_in.to_boot
    && req_in.from_boot && !app_hi |=> access_deny_out)
    else $error("boot read of app allowed");
  a_boot_store_lock: assert property (
    req_in.valid && req_in.is_store && req_in.to_boot && !boot_lo
    |=> access_deny_out)
    else $error("store to locked boot allowed");
  a_boot_read_open: assert property (
    req_in.valid && !req_in.is_store && req_in.to_boot && boot_hi
    |=> access_allow_out)
    else $error("boot table read denied");
  a_boot_cross_read: assert property (
    req_in.valid && !req_in.is_store && req_in.to_boot
    && !req_in.from_boot && !boot_hi |=> access_deny_out)
    else $error("app read of boot allowed");
  a_boot_store_open: assert property (
    req_in.valid && req_in.is_store && req_in.to_boot && boot_lo
    |=> access_allow_out)
    else $error("boot store wrongly denied");
  a_own_read_open: assert property (
    req_in.valid && !req_in.is_store && req_in.to_boot == req_in.from_boot
    |=> access_allow_out)
    else $error("read of own section denied");
  a_no_req_quiet: assert property (
    !req_in.valid |=> !access_allow_out && !access_deny_out)
    else $error("access answer without request");
  a_app_irq_mask: assert property (
    vectors_in_boot_in && !exec_in_boot_in && !app_hi
    |=> irq_mask_out)
    else $error("application code not masked");
  a_boot_irq_mask: assert property (
    !vectors_in_boot_in && exec_in_boot_in && !boot_hi
    |=> irq_mask_out)
    else $error("boot code not masked");
  a_irq_mask_open: assert property (
    app_hi && boot_hi |=> !irq_mask_out)
    else $error("interrupts masked with open locks");
  a_fuse_write_lock: assert property (
    in_prog && prog_wr_in && !prog_erase_in && locked
    && prog_sel_in != lfag_pkg::LFAG_SEL_LOCK
    |=> prog_refused_out && $stable(s_q.high_nv))
    else $error("fuse write while locked");
  a_lock_only_erase: assert property (
    !(in_prog && prog_erase_in)
    |=> (s_q.lock_nv & ~$past(s_q.lock_nv)) == 8'h00)
    else $error("lock bit cleared without erase");
  a_erase_locks_open: assert property (
    in_prog && prog_erase_in
    |=> s_q.lock_nv == `LFAG_LOCK_DEFAULT && prog_done_out)
    else $error("chip erase left a lock bit");
  a_erase_keeps_fuse: assert property (
    in_prog && prog_erase_in |=> $stable(s_q.low_nv)
    && $stable(s_q.ext_nv) && $stable(s_q.high_nv))
    else $error("chip erase altered fuses");
  a_latch_in_session: assert property (
    in_prog && $past(in_prog) && s_q.prog_s2 && s_q.pwr_seen
    |=> $stable(s_q.low_lat))
    else $error("latched fuse moved in session");
  a_outside_quiet: assert property (
    !in_prog |=> !prog_done_out && !prog_refused_out && !prog_rvalid_out)
    else $error("programmer answered outside session");
  a_power_latch: assert property (
    !s_q.pwr_seen |=> s_q.low_lat == $past(s_q.low_nv))
    else $error("fuses not captured at power-up");
  a_sig_byte0: assert property (
    in_prog && prog_rd_in && !prog_wr_in && !prog_erase_in && prog_sig_in
    && prog_sel_in == `LFAG_SIG_ADDR0
    |=> prog_rvalid_out && prog_rdata_out == SIG_BYTE0)
    else $error("signature byte wrong");
  a_ext_read_zero: assert property (
    in_prog && prog_rd_in && !prog_wr_in && !prog_erase_in && !prog_sig_in
    && prog_sel_in == lfag_pkg::LFAG_SEL_EXT |=> prog_rdata_out[7:3] == 5'h00)
    else $error("unused extended bits read as 1");
  a_serial_dl_kept: assert property (
    in_prog && prog_wr_in && !prog_erase_in && prog_serial_in
    |=> $stable(s_q.high_nv[`LFAG_HI_SERIAL_DL]))
    else $error("serial write altered download bit");
  a_serial_dl_hidden: assert property (
    in_prog && prog_rd_in && !prog_wr_in && !prog_erase_in && !prog_sig_in
    && prog_serial_in && prog_sel_in == lfag_pkg::LFAG_SEL_HIGH
    |=> prog_rdata_out[`LFAG_HI_SERIAL_DL])
    else $error("serial read showed download bit");
  a_ee_keep_now: assert property (
    !s_q.high_nv[`LFAG_HI_EE_SAVE] |=> eeprom_keep_out)
    else $error("erase-preserve not applied");

  c_store_denied: cover property (access_deny_out);
  c_fuse_written: cover property (prog_done_out);
  c_sig_read:     cover property (in_prog && prog_rd_in && prog_sig_in);
  c_irq_masked:   cover property (irq_mask_out);
  c_write_refused: cover property (prog_refused_out);

endmodule : lfag_guard
`default_nettype wire

/* test/lfag_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lfag_prog_model (
  // clock
  input  wire logic       core_clk_in,
  // device answers
  input  wire logic [7:0] prog_rdata_in,
  input  wire logic       prog_rvalid_in,
  input  wire logic       prog_refused_in,
  input  wire logic       prog_done_in,
  // programmer drive
  output logic            prog_mode_out,
  output logic            prog_serial_out,
  output logic            prog_wr_out,
  output logic            prog_rd_out,
  output logic            prog_erase_out,
  output logic            prog_sig_out,
  output logic [1:0]      prog_sel_out,
  output logic [7:0]      prog_wdata_out
);
  initial begin
    // data and select stay unknown until the first command drives them
    {prog_mode_out, prog_wr_out, prog_rd_out} = 3'h0;
    {prog_erase_out, prog_sig_out} = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode pin is synchronised inside, so allow a few edges either way
  task automatic session(input logic on);
    @(posedge core_clk_in);
    prog_mode_out <= on;
    repeat (5) @(posedge core_clk_in);
  endtask : session

  // one strobe cycle; answer sampled once the next edge has landed
  task automatic op(input logic wr, input logic rd, input logic er,
                    input logic sig, input logic ser, input logic [1:0] sel,
                    input logic [7:0] d, output logic [7:0] r,
                    output logic [2:0] rsp);
    @(posedge core_clk_in);
    prog_wr_out     <= wr;
    prog_rd_out     <= rd;
    prog_erase_out  <= er;
    prog_sig_out    <= sig;
    prog_serial_out <= ser;
    prog_sel_out    <= sel;
    prog_wdata_out  <= d;
    @(posedge core_clk_in);
    prog_wr_out    <= 1'b0;
    prog_rd_out    <= 1'b0;
    prog_erase_out <= 1'b0;
    // released data no longer shows the old byte
    prog_wdata_out <= ~d;
    #1;
    r   = prog_rdata_in;
    rsp = {prog_rvalid_in, prog_done_in, prog_refused_in};
  endtask : op
endmodule : lfag_prog_model

`default_nettype wire

/* test/lfag_guard_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module lfag_guard_tb;
  logic                core_clk_in;
  logic                srst_in;
  lfag_pkg::lfag_req_s req;
  logic                vec_boot;
  logic                exec_boot;
  logic                allow, deny, irq_mask, keep;
  logic                pmode, pser, pwr, prd, per, psig;
  logic                rvalid, refused, done;
  logic [1:0]          psel;
  logic [7:0]          pwd, prdata, rb;
  logic [2:0]          rsp;
  lfag_pkg::lfag_cfg_s cfg;
  int                  fails, num_checks, cycles;

  lfag_guard dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .req_in(req),
    .vectors_in_boot_in(vec_boot), .exec_in_boot_in(exec_boot),
    .access_allow_out(allow), .access_deny_out(deny),
    .irq_mask_out(irq_mask), .prog_mode_in(pmode), .prog_serial_in(pser),
    .prog_wr_in(pwr), .prog_rd_in(prd), .prog_erase_in(per),
    .prog_sig_in(psig), .prog_sel_in(psel), .prog_wdata_in(pwd),
    .prog_rdata_out(prdata), .prog_rvalid_out(rvalid),
    .prog_refused_out(refused), .prog_done_out(done), .cfg_out(cfg),
    .eeprom_keep_out(keep));

  lfag_prog_model prog (
    .core_clk_in(core_clk_in), .prog_rdata_in(prdata),
    .prog_rvalid_in(rvalid), .prog_refused_in(refused),
    .prog_done_in(done), .prog_mode_out(pmode), .prog_serial_out(pser),
    .prog_wr_out(pwr), .prog_rd_out(prd), .prog_erase_out(per),
    .prog_sig_out(psig), .prog_sel_out(psel), .prog_wdata_out(pwd));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic rd(input logic ser, input logic sig, input logic [1:0] sel,
                    input logic [7:0] exp);
    prog.op(1'b0, 1'b1, 1'b0, sig, ser, sel, 8'h00, rb, rsp);
    check(rsp[2] === 1'b1 && rb === exp, "programmer read");
  endtask : rd

  task automatic wr(input logic ser, input logic [1:0] sel,
                    input logic [7:0] d);
    prog.op(1'b1, 1'b0, 1'b0, 1'b0, ser, sel, d, rb, rsp);
  endtask : wr

  task automatic erase();
    prog.op(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 8'h00, rb, rsp);
    check(rsp[1] === 1'b1, "erase not done");
  endtask : erase

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    check(cfg === {8'h99, 8'h62, 3'h7} && keep === 1'b0, "power-up");
    prog.session(1'b1);
    rd(1'b0, 1'b0, 2'h0, 8'h62);
    rd(1'b0, 1'b0, 2'h1, 8'h99);
    rd(1'b0, 1'b0, 2'h2, 8'h07);
    rd(1'b0, 1'b0, 2'h3, 8'hFF);
    rd(1'b0, 1'b1, 2'h0, 8'hA5);
    rd(1'b0, 1'b1, 2'h1, 8'h5A);
    rd(1'b0, 1'b1, 2'h2, 8'h3C);
  endtask : t_defaults

  task automatic t_fuse_session();
    wr(1'b0, 2'h0, 8'h60);
    check(rsp[1] === 1'b1, "low write not done");
    rd(1'b0, 1'b0, 2'h0, 8'h60);
    check(cfg === {8'h99, 8'h62, 3'h7}, "fuse applied mid-session");
    wr(1'b0, 2'h1, 8'h91);
    // keep output is registered from the stored bit one edge later
    @(posedge core_clk_in);
    #1;
    check(keep === 1'b1, "erase-preserve late");
    erase();
    rd(1'b0, 1'b0, 2'h0, 8'h60);
    rd(1'b0, 1'b0, 2'h1, 8'h91);
    prog.session(1'b0);
    check(cfg === {8'h91, 8'h60, 3'h7}, "fuse not applied");
  endtask : t_fuse_session

  task automatic t_serial();
    prog.session(1'b1);
    wr(1'b1, 2'h1, 8'hB9);
    rd(1'b1, 1'b0, 2'h1, 8'hB9);
    rd(1'b0, 1'b0, 2'h1, 8'h99);
    check(keep === 1'b0, "erase-preserve kept");
    prog.session(1'b0);
  endtask : t_serial

  // same two-bit code in both section fields, so the decode is symmetric
  task automatic t_access(input logic [1:0] c);
    logic exp;
    for (int k = 0; k < 8; k++) begin
      exp = k[2] ? c[0] : ((k[1] != k[0]) ? c[1] : 1'b1);
      @(posedge core_clk_in);
      req <= {1'b1, k[2], k[1], k[0]};
      @(posedge core_clk_in);
      req <= '0;
      #1;
      check(allow === exp && deny === !exp, "access");
    end
    for (int v = 0; v < 4; v++) begin
      @(posedge core_clk_in);
      vec_boot  <= v[1];
      exec_boot <= v[0];
      repeat (2) @(posedge core_clk_in);
      #1;
      check(irq_mask === (!c[1] && v[1] != v[0]), "irq mask");
    end
  endtask : t_access

  task automatic t_locks();
    for (int c = 0; c < 4; c++) begin
      prog.session(1'b1);
      erase();
      rd(1'b0, 1'b0, 2'h3, 8'hFF);
      wr(1'b0, 2'h3, {2'b11, c[1:0], c[1:0], 2'b11});
      rd(1'b0, 1'b0, 2'h3, {2'b11, c[1:0], c[1:0], 2'b11});
      prog.session(1'b0);
      t_access(c[1:0]);
    end
  endtask : t_locks

  task automatic t_memlock();
    prog.session(1'b1);
    wr(1'b0, 2'h3, 8'hFE);
    rd(1'b0, 1'b0, 2'h3, 8'hFE);
    wr(1'b0, 2'h0, 8'h00);
    check(rsp[0] === 1'b1, "locked fuse write accepted");
    rd(1'b0, 1'b0, 2'h0, 8'h60);
    rd(1'b0, 1'b1, 2'h0, 8'hA5);
    erase();
    rd(1'b0, 1'b0, 2'h3, 8'hFF);
    prog.session(1'b0);
  endtask : t_memlock

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    srst_in   = 1'b1;
    req       = '0;
    vec_boot  = 1'b0;
    exec_boot = 1'b0;
    repeat (6) @(posedge core_clk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    t_defaults();
    t_fuse_session();
    t_serial();
    t_locks();
    t_memlock();
    summarize();
  end
endmodule : lfag_guard_tb

`default_nettype wire
